// file: pomk_pkg.sv
// Purpose: Shared constants for the PWM output init and mask block.
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register.
// Notes: Printed offsets are register indices; byte address is four times the index.
package pomk_pkg;
  localparam int          POMK_NUM_CH       = 8;
  localparam int          POMK_AW           = 8;
  localparam logic [7:0]  POMK_IDX_INIT     = 8'h1C;
  localparam logic [7:0]  POMK_IDX_MASK     = 8'h1D;
  localparam logic [7:0]  POMK_IDX_CTRL     = 8'h20;
  localparam logic [7:0]  POMK_IDX_STAT     = 8'h21;
  localparam logic [7:0]  POMK_ADDR_INIT    = 8'(POMK_IDX_INIT * 4);
  localparam logic [7:0]  POMK_ADDR_MASK    = 8'(POMK_IDX_MASK * 4);
  localparam logic [7:0]  POMK_ADDR_CTRL    = 8'(POMK_IDX_CTRL * 4);
  localparam logic [7:0]  POMK_ADDR_STAT    = 8'(POMK_IDX_STAT * 4);
  localparam int          POMK_CTRL_SYNSEL  = 0;
  localparam logic [7:0]  POMK_RST_INIT     = 8'h00;
  localparam logic [7:0]  POMK_RST_MASK     = 8'h00;
  localparam logic [1:0]  POMK_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  POMK_RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {POMK_REG_NONE, POMK_REG_INIT, POMK_REG_MASK, POMK_REG_CTRL} pomk_reg_t;
endpackage

// file: pomk_cfg_if.sv
// Purpose: Carries the register values from the bus slave to the output stage.
// Assumes: One system clock.
// Notes: The slave drives the register values, the output stage reads them and drives mask_active back.
interface pomk_cfg_if;
  logic [7:0] init_values;
  logic [7:0] mask_wbuf;
  logic       sync_select;
  logic [7:0] mask_active;
  modport slave (output init_values, output mask_wbuf, output sync_select, input mask_active);
  modport stage (input init_values, input mask_wbuf, input sync_select, output mask_active);
endinterface

// file: pomk_out_stage.sv
// Purpose: Active mask update and per-channel output forcing.
// Assumes: Strobes are one-cycle pulses synchronous to the clock.
// Notes: Outputs are registered, so they lag the channel logic by one cycle.
module pomk_out_stage
  import pomk_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration
  pomk_cfg_if.stage       cfg,
  // Channel side
  input  wire logic [7:0] pwm_in,
  input  wire logic [7:0] inactive_lvl,
  input  wire logic       init_stb,
  input  wire logic       sync_evt,
  output logic      [7:0] chan_out
);
  logic [7:0] mask_ff;

  assign cfg.mask_active = mask_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= POMK_RST_MASK;
    end else if (!cfg.sync_select || sync_evt) begin // [R08] [R09]
      mask_ff <= cfg.mask_wbuf;
    end
  end

  genvar g;
  generate
    for (g = 0; g < POMK_NUM_CH; g++) begin : g_ch
      always_ff @(posedge clk) begin
        if (rst) begin
          chan_out[g] <= 1'b0;
        end else if (init_stb) begin
          chan_out[g] <= cfg.init_values[g]; // [R02] [R03] [R10]
        end else if (mask_ff[g]) begin
          chan_out[g] <= inactive_lvl[g]; // [R05]
        end else begin
          chan_out[g] <= pwm_in[g]; // [R04] [R06]
        end
      end
    end
  endgenerate
endmodule

// file: pomk_top.sv
// Purpose: PWM output init values and double-buffered output mask with AXI4-Lite access.
// Assumes: One 50 MHz clock, synchronous active-high reset, inputs synchronous to it.
// Notes: Unmapped addresses answer SLVERR; writes there have no effect.
// Function
// R01 - There are eight init-value bits, bit n belonging to channel n.
// R02 - On an output initialization each channel output takes its init-value bit.
// R03 - An init-value bit of 1 forces the output high and 0 forces it low.
// R04 - Eight mask bits decide per channel whether the output reacts to compare matches.
// R05 - A channel with mask bit 1 is held at its inactive level.
// R06 - A channel with mask bit 0 follows its PWM or compare logic.
// R07 - Software writes to the mask land in a write buffer, not the active mask.
// R08 - The active mask is loaded from the write buffer under synchronization control.
// R09 - With the select bit 0 the mask copies every clock edge, with 1 only on a sync event.
// R10 - A one-cycle init strobe sets all eight outputs in the following cycle.
module pomk_top
  import pomk_pkg::*;
(
  // Clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  // AXI4-Lite write address
  input  wire logic [POMK_AW-1:0] AWADDR,
  input  wire logic               AWVALID,
  output logic                    AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]        WDATA,
  input  wire logic [3:0]         WSTRB,
  input  wire logic               WVALID,
  output logic                    WREADY,
  // AXI4-Lite write response
  output logic [1:0]              BRESP,
  output logic                    BVALID,
  input  wire logic               BREADY,
  // AXI4-Lite read address
  input  wire logic [POMK_AW-1:0] ARADDR,
  input  wire logic               ARVALID,
  output logic                    ARREADY,
  // AXI4-Lite read data
  output logic [31:0]             RDATA,
  output logic [1:0]              RRESP,
  output logic                    RVALID,
  input  wire logic               RREADY,
  // Channel side
  input  wire logic [7:0]         PWM_IN,
  input  wire logic [7:0]         INACTIVE_LVL,
  input  wire logic               INIT_STB,
  input  wire logic               SYNC_EVT,
  output logic      [7:0]         CHAN_OUT
);
  // One decoder serves both address channels, so a write and a read of the same offset always
  // land on the same register even when both are under way in one cycle.
  function automatic pomk_reg_t decode(input logic [POMK_AW-1:0] a);
    if (a == POMK_ADDR_INIT) begin
      return POMK_REG_INIT;
    end else if (a == POMK_ADDR_MASK) begin
      return POMK_REG_MASK;
    end else if (a == POMK_ADDR_CTRL) begin
      return POMK_REG_CTRL;
    end else begin
      return POMK_REG_NONE;
    end
  endfunction

  // Every register is one byte wide or less, so the upper bits of a read word are always zero.
  // An unmapped offset reads as zero as well; its refusal is carried by the response code.
  function automatic logic [31:0] read_word(input pomk_reg_t  sel,
                                            input logic [7:0] init,
                                            input logic [7:0] mask,
                                            input logic       ctl);
    logic [31:0] w;
    w = 32'h00000000;
    case (sel)
      POMK_REG_INIT: begin
        w[7:0] = init;
      end
      POMK_REG_MASK: begin
        w[7:0] = mask;
      end
      POMK_REG_CTRL: begin
        w[POMK_CTRL_SYNSEL] = ctl;
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction

  pomk_cfg_if cfg ();

  logic [7:0]         init_ff;
  logic [7:0]         wbuf_ff;
  logic               sel_ff;
  logic               aw_got_ff;
  logic               w_got_ff;
  logic [POMK_AW-1:0] awaddr_ff;
  logic [31:0]        wdata_ff;
  logic               wstrb0_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [31:0]        rdata_ff;
  logic [1:0]         rresp_ff;
  logic               wr_go;
  logic               wr_lane;
  logic               wr_init;
  logic               wr_mask;
  logic               wr_ctrl;
  pomk_reg_t          wr_sel;
  pomk_reg_t          rd_sel;

  // Per-register write strobes, valid only in the commit cycle.
  assign wr_lane = wr_go && wstrb0_ff;
  assign wr_init = wr_lane && (wr_sel == POMK_REG_INIT);
  assign wr_mask = wr_lane && (wr_sel == POMK_REG_MASK);
  assign wr_ctrl = wr_lane && (wr_sel == POMK_REG_CTRL);

  // Address and data are taken independently; the write commits once both are held.
  assign AWREADY = !aw_got_ff && !bvalid_ff;
  assign WREADY  = !w_got_ff && !bvalid_ff;
  assign wr_go   = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_sel  = decode(awaddr_ff);
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = !rvalid_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;
  assign rd_sel  = decode(ARADDR);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= AWADDR;
    end else if (wr_go) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      w_got_ff  <= 1'b0;
      wdata_ff  <= '0;
      wstrb0_ff <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_got_ff  <= 1'b1;
      wdata_ff  <= WDATA;
      wstrb0_ff <= WSTRB[0];
    end else if (wr_go) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= POMK_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_sel == POMK_REG_NONE) ? POMK_RESP_SLVERR : POMK_RESP_OKAY;
    end else if (BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Registers only hold byte lane 0, so a write without WSTRB[0] changes nothing.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      init_ff <= POMK_RST_INIT;
    end else if (wr_init) begin
      init_ff <= wdata_ff[7:0]; // [R01]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wbuf_ff <= POMK_RST_MASK;
    end else if (wr_mask) begin
      wbuf_ff <= wdata_ff[7:0]; // [R07]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sel_ff <= 1'b0;
    end else if (wr_ctrl) begin
      sel_ff <= wdata_ff[POMK_CTRL_SYNSEL]; // [R09]
    end
  end

  // Reading the mask returns the active bits, which shows whether a sync has landed.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= POMK_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= read_word(rd_sel, init_ff, cfg.mask_active, sel_ff);
      if (rd_sel == POMK_REG_NONE) begin
        rresp_ff <= POMK_RESP_SLVERR;
      end else begin
        rresp_ff <= POMK_RESP_OKAY;
      end
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // The write buffer is what software wrote; the stage decides when it becomes the active mask.
  assign cfg.init_values = init_ff;
  assign cfg.mask_wbuf   = wbuf_ff;
  assign cfg.sync_select = sel_ff;

  pomk_out_stage u_stage (
    .clk          (CLK_SYS),
    .rst          (RST),
    .cfg          (cfg.stage),
    .pwm_in       (PWM_IN),
    .inactive_lvl (INACTIVE_LVL),
    .init_stb     (INIT_STB),
    .sync_evt     (SYNC_EVT),
    .chan_out     (CHAN_OUT)
  );
endmodule

// file: pomk_top_checker.sv
// Purpose: Port checks for the output init and mask block.
// Assumes: The master offers AW and W together.
// Notes: The init shadow tracks writes taken at the ports.
module pomk_top_checker
  import pomk_pkg::*;
(
  // Clock, reset, handshakes and strobes
  input wire logic        CLK_SYS, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID,
  input wire logic        BREADY, ARVALID, ARREADY, RVALID, RREADY, INIT_STB, SYNC_EVT,
  // Payloads
  input wire logic [7:0]  AWADDR, ARADDR, CHAN_OUT,
  input wire logic [31:0] WDATA, RDATA,
  input wire logic [3:0]  WSTRB,
  input wire logic [1:0]  BRESP, RRESP
);
  logic [7:0] sh_init_ff;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  always_ff @(posedge CLK_SYS) begin
    if (RST)
      sh_init_ff <= 8'h00;
    else if (AWVALID && AWREADY && WVALID && WREADY && AWADDR == POMK_ADDR_INIT && WSTRB[0])
      sh_init_ff <= WDATA[7:0];
  end
  a_init_apply: assert property (INIT_STB |=> CHAN_OUT == sh_init_ff)
    else $error("init values not on outputs");
  a_read_width: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_busy_block: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  a_read_slverr: assert property (ARVALID && ARREADY && ARADDR == POMK_ADDR_STAT
    |=> RRESP == POMK_RESP_SLVERR && RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  cover property (INIT_STB);
  cover property (SYNC_EVT);
  cover property (BVALID && BRESP == POMK_RESP_SLVERR);
endmodule
bind pomk_top pomk_top_checker pomk_top_checker_inst (.CLK_SYS, .RST, .AWVALID, .AWREADY,
  .WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .INIT_STB,
  .SYNC_EVT, .AWADDR, .ARADDR, .CHAN_OUT, .WDATA, .RDATA, .WSTRB, .BRESP, .RRESP);

// file: pomk_top_test.sv
// Purpose: Self-checking bench for the output init and mask block.
// Assumes: One write and one read under way at a time.
// Notes: Outputs are sampled on the falling edge.
module pomk_top_test
  import pomk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_SYS, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, INIT_STB, SYNC_EVT;
  logic [7:0]  AWADDR, ARADDR, PWM_IN, INACTIVE_LVL, CHAN_OUT;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  int          num_errors = 0;
  int          n_tests = 0;
  pomk_top pomk_top_inst (.CLK_SYS, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .PWM_IN, .INACTIVE_LVL, .INIT_STB, .SYNC_EVT, .CHAN_OUT);
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // A wait that runs out ends the run, since later checks would only cascade.
  task automatic limit(input int n);
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask
  function automatic logic [31:0] out_exp(logic [7:0] m, logic [7:0] il, logic [7:0] pw);
    return {24'h000000, (m & il) | (~m & pw)};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int   n = 0;
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge CLK_SYS);
    {AWADDR, WDATA, WSTRB} <= {a, d, 4'hF};
    {AWVALID, WVALID, BREADY} <= 3'h7;
    do begin
      @(posedge CLK_SYS);
      n++;
      if (!aw_done && AWREADY) begin
        aw_done = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w_done && WREADY) begin
        w_done = 1'b1;
        WVALID <= 1'b0;
      end
    end while (!(aw_done && w_done) && n < 50);
    limit(n);
    n = 0;
    do begin @(posedge CLK_SYS); n++; end while (!BVALID && n < 50);
    BREADY <= 1'b0;
    limit(n);
    chk({30'h0, BRESP}, {30'h0, r}, "bresp");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge CLK_SYS);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    do begin @(posedge CLK_SYS); n++; end while (!ARREADY && n < 50);
    ARVALID <= 1'b0;
    limit(n);
    n = 0;
    do begin @(posedge CLK_SYS); n++; end while (!RVALID && n < 50);
    RREADY <= 1'b0;
    limit(n);
    chk(RDATA, d, "rdata");
    chk({30'h0, RRESP}, {30'h0, r}, "rresp");
  endtask
  task automatic t_init();
    axi_rd(POMK_ADDR_INIT, {24'h0, POMK_RST_INIT}, POMK_RESP_OKAY);
    axi_rd(POMK_ADDR_MASK, {24'h0, POMK_RST_MASK}, POMK_RESP_OKAY);
    PWM_IN <= 8'h5A;
    axi_wr(POMK_ADDR_INIT, 32'hA5, POMK_RESP_OKAY);
    axi_rd(POMK_ADDR_INIT, 32'hA5, POMK_RESP_OKAY);
    @(posedge CLK_SYS);
    INIT_STB <= 1'b1;
    @(posedge CLK_SYS);
    INIT_STB <= 1'b0;
    tick(0);
    chk({24'h0, CHAN_OUT}, 32'hA5, "init");
    tick(1);
    chk({24'h0, CHAN_OUT}, 32'h5A, "after init");
  endtask
  task automatic t_mask();
    {INACTIVE_LVL, PWM_IN} <= {8'h0F, 8'hF0};
    axi_wr(POMK_ADDR_MASK, 32'h3C, POMK_RESP_OKAY);
    tick(1);
    chk({24'h0, CHAN_OUT}, out_exp(8'h3C, 8'h0F, 8'hF0), "free");
    axi_wr(POMK_ADDR_CTRL, 32'h1, POMK_RESP_OKAY);
    axi_wr(POMK_ADDR_MASK, 32'hFF, POMK_RESP_OKAY);
    tick(3);
    chk({24'h0, CHAN_OUT}, out_exp(8'h3C, 8'h0F, 8'hF0), "held");
    axi_rd(POMK_ADDR_MASK, 32'h3C, POMK_RESP_OKAY);
    @(posedge CLK_SYS);
    SYNC_EVT <= 1'b1;
    @(posedge CLK_SYS);
    SYNC_EVT <= 1'b0;
    tick(1);
    chk({24'h0, CHAN_OUT}, out_exp(8'hFF, 8'h0F, 8'hF0), "synced");
    axi_rd(POMK_ADDR_MASK, 32'hFF, POMK_RESP_OKAY);
    axi_wr(POMK_ADDR_STAT, 32'hFF, POMK_RESP_SLVERR);
    axi_rd(POMK_ADDR_STAT, 32'h0, POMK_RESP_SLVERR);
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, INIT_STB, SYNC_EVT} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB, PWM_IN, INACTIVE_LVL} = '0;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_init();
    t_mask();
    print_verdict();
  end
endmodule
